/* rtl/bcr_map.vh */
// Register offsets, field positions and reset values of the clock-run and capability bank.
`ifndef BCR_MAP_VH
`define BCR_MAP_VH
`define BCR_OFF_CLKRUN_CTRL 8'ha4
`define BCR_OFF_SUBSYS_CAP 8'ha8
`define BCR_OFF_CARD_ID 8'hac
`define BCR_OFF_EXPRESS_CAP 8'hb0
`define BCR_OFF_SLOT_ID_CFG 8'hc0
`define BCR_OFF_BRIDGE_STATUS 8'hc4
`define BCR_CLK_SLOT0_LSB 0
`define BCR_CLK_SLOT3_LSB 6
`define BCR_CLK_DISABLE_CODE 2'h3
`define BCR_STOP_STATUS_BIT 13
`define BCR_CLKRUN_EN_BIT 14
`define BCR_CLKRUN_MODE_BIT 15
`define BCR_L0S_GATE_BIT 16
`define BCR_SCRAMBLE_LSB 17
`define BCR_RW_MASK 32'h0007c0ff
`define BCR_CLKRUN_RESET 32'h00010000
`define BCR_SUBSYS_CAP_ID 8'h0d
`define BCR_NEXT_TO_EXPRESS 8'hb0
`define BCR_NEXT_TO_SLOT_ID 8'ha0
`define BCR_EXPRESS_CAP_ID 8'h10
`define BCR_EXPRESS_NEXT 8'hf0
`define BCR_EXPRESS_VERSION 4'h1
`define BCR_PORT_FORWARD 4'h7
`define BCR_PORT_REVERSE 4'h8
`define BCR_RESP_OKAY 2'h0
`define BCR_RESP_SLVERR 2'h2
`endif

/* rtl/bcr_regs.v */
// Clock-run control and capability registers of the bridge, reached over AXI4-Lite.
`timescale 1ns/10ps
`include "bcr_map.vh"

module bcr_regs #(
  parameter [15:0] CARD_VENDOR_ID = 16'h0000,
  parameter [15:0] CARD_ID = 16'h0000,
  parameter NUM_SLOTS = 4
) (
  input wire clk_i,
  input wire resetn_i,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire reverse_bridge_i,
  input wire d3hot_i,
  input wire secondary_bus_idle_i,
  input wire primary_request_pending_i,
  input wire receiver_elec_idle_i,
  input wire l0s_request_i,
  input wire eeprom_cfg_write_i,
  input wire eeprom_slot_id_en_i,
  input wire sec_clock_i,
  output wire [NUM_SLOTS-1:0] slot_clock_out_o,
  output wire slot0_secondary_clock_out_o,
  output wire slot3_secondary_clock_out_o,
  output reg sec_clock_stopped_o,
  output wire l0s_enter_o
);

  reg [31:0] clkrun_ctrl;
  reg slot_id_en;
  reg [7:0] aw_addr;
  reg aw_held;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg w_held;
  reg [31:0] next_rdata;
  reg next_mapped;
  reg [31:0] next_ctrl;
  reg wr_mapped;
  reg [31:0] clkrun_word;
  reg [31:0] subsys_word;
  reg [31:0] card_word;
  reg [31:0] express_word;
  reg [31:0] slot_cfg_word;
  reg [31:0] status_word;
  wire [7:0] rd_addr;
  wire aw_take;
  wire w_take;
  wire ar_take;
  wire do_write;
  wire stop_request;
  wire mode_stop;
  wire l0s_allowed;
  wire [7:0] subsys_next;
  wire [3:0] port_type;
  genvar g;

  function [31:0] bcr_merge;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0] strb;
    integer k;
    begin
      bcr_merge = old_val;
      for (k = 0; k < 4; k = k + 1) begin
        if (strb[k]) begin
          bcr_merge[k*8 +: 8] = new_val[k*8 +: 8];
        end
      end
    end
  endfunction

  function is_mapped;
    input [7:0] addr;
    begin
      case (addr)
        `BCR_OFF_CLKRUN_CTRL,
        `BCR_OFF_SUBSYS_CAP,
        `BCR_OFF_CARD_ID,
        `BCR_OFF_EXPRESS_CAP,
        `BCR_OFF_SLOT_ID_CFG,
        `BCR_OFF_BRIDGE_STATUS: begin
          is_mapped = 1'b1;
        end
        default: is_mapped = 1'b0;
      endcase
    end
  endfunction

  // Byte lanes inside a word are dropped, so every register answers on its whole word.
  function [7:0] word_align;
    input [7:0] addr;
    begin
      word_align = {addr[7:2], 2'b00};
    end
  endfunction

  // A code of 11 turns a slot off on a forward bridge only; the other three codes all leave it running.
  function slot_off;
    input [31:0] ctrl;
    input integer slot;
    begin
      slot_off = (ctrl[2*slot +: 2] == `BCR_CLK_DISABLE_CODE);
    end
  endfunction

  assign subsys_next = slot_id_en ? `BCR_NEXT_TO_SLOT_ID : `BCR_NEXT_TO_EXPRESS;
  assign port_type = reverse_bridge_i ? `BCR_PORT_REVERSE : `BCR_PORT_FORWARD;

  // Mode 0 waits for D3hot; mode 1 stops on an idle bus with nothing pending upstream.
  assign mode_stop = clkrun_ctrl[`BCR_CLKRUN_MODE_BIT] ?
    (secondary_bus_idle_i & ~primary_request_pending_i) :
    d3hot_i;
  assign stop_request = clkrun_ctrl[`BCR_CLKRUN_EN_BIT] & mode_stop;

  // Registered so the gate never follows a glitch on the idle or request inputs.
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sec_clock_stopped_o <= 1'b0;
    end else begin
      sec_clock_stopped_o <= stop_request;
    end
  end

  // Gating is on the raw clock, so a glitch-free gate cell belongs here in silicon.
  generate
    for (g = 0; g < NUM_SLOTS; g = g + 1) begin : slot_gate
      assign slot_clock_out_o[g] = sec_clock_i & ~sec_clock_stopped_o &
        ~(~reverse_bridge_i & slot_off(clkrun_ctrl, g));
    end
  endgenerate
  assign slot0_secondary_clock_out_o = slot_clock_out_o[`BCR_CLK_SLOT0_LSB / 2];
  assign slot3_secondary_clock_out_o = slot_clock_out_o[`BCR_CLK_SLOT3_LSB / 2];

  assign l0s_allowed = ~clkrun_ctrl[`BCR_L0S_GATE_BIT] | receiver_elec_idle_i;
  assign l0s_enter_o = l0s_request_i & l0s_allowed;

  // Slot identification can only be turned on by the serial configuration memory loader.
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      slot_id_en <= 1'b0;
    end else if (eeprom_cfg_write_i) begin
      slot_id_en <= eeprom_slot_id_en_i;
    end
  end

  // Write channel: address and data are caught in either order, one write at a time.
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held & ~s_axi_bvalid;
  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take = s_axi_wvalid & s_axi_wready;
  assign do_write = aw_held & w_held & ~s_axi_bvalid;

  always @* begin
    wr_mapped = is_mapped(aw_addr);
    next_ctrl = clkrun_ctrl;
    if (aw_addr == `BCR_OFF_CLKRUN_CTRL) begin
      next_ctrl = bcr_merge(clkrun_ctrl, w_data, w_strb);
      next_ctrl = (next_ctrl & `BCR_RW_MASK) | (clkrun_ctrl & ~`BCR_RW_MASK);
    end
  end

  // Address and data sit in their own holding registers until both have arrived.
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      aw_addr <= 8'h00;
      aw_held <= 1'b0;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end else if (aw_take) begin
      aw_addr <= word_align(s_axi_awaddr);
      aw_held <= 1'b1;
    end
  end

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      w_held <= 1'b0;
    end else if (do_write) begin
      w_held <= 1'b0;
    end else if (w_take) begin
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
      w_held <= 1'b1;
    end
  end

  // A write to an unmapped offset still answers, so a probing host never hangs.
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `BCR_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_mapped ? `BCR_RESP_OKAY : `BCR_RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Only the writable bits ever change; stop status is never stored here.
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      clkrun_ctrl <= `BCR_CLKRUN_RESET;
    end else if (do_write) begin
      clkrun_ctrl <= next_ctrl;
    end
  end

  // Read channel: the word is assembled from live state, so stop status is current.
  assign s_axi_arready = ~s_axi_rvalid;
  assign ar_take = s_axi_arvalid & s_axi_arready;
  assign rd_addr = word_align(s_axi_araddr);

  // Each readable word is built on its own, with every unused bit held at zero.
  always @* begin
    clkrun_word = clkrun_ctrl & `BCR_RW_MASK;
    clkrun_word[`BCR_STOP_STATUS_BIT] = sec_clock_stopped_o;
  end

  always @* begin
    subsys_word = 32'h00000000;
    subsys_word[7:0] = `BCR_SUBSYS_CAP_ID;
    subsys_word[15:8] = subsys_next;
  end

  // Card identifiers are fixed at build time; software cannot change them.
  always @* begin
    card_word = 32'h00000000;
    card_word[15:0] = CARD_VENDOR_ID;
    card_word[31:16] = CARD_ID;
  end

  // Port type and slot bit follow the strap live, so a strap change shows at once.
  always @* begin
    express_word = 32'h00000000;
    express_word[7:0] = `BCR_EXPRESS_CAP_ID;
    express_word[15:8] = `BCR_EXPRESS_NEXT;
    express_word[19:16] = `BCR_EXPRESS_VERSION;
    express_word[23:20] = port_type;
    express_word[24] = reverse_bridge_i;
  end

  always @* begin
    slot_cfg_word = 32'h00000000;
    slot_cfg_word[0] = slot_id_en;
  end

  // Raw stop request is shown here for debug, one cycle ahead of the status bit.
  always @* begin
    status_word = 32'h00000000;
    status_word[0] = stop_request;
    status_word[1] = reverse_bridge_i;
  end

  always @* begin
    next_rdata = 32'h00000000;
    next_mapped = 1'b1;
    case (rd_addr)
      `BCR_OFF_CLKRUN_CTRL: begin
        next_rdata = clkrun_word;
      end
      `BCR_OFF_SUBSYS_CAP: begin
        next_rdata = subsys_word;
      end
      `BCR_OFF_CARD_ID: begin
        next_rdata = card_word;
      end
      `BCR_OFF_EXPRESS_CAP: begin
        next_rdata = express_word;
      end
      `BCR_OFF_SLOT_ID_CFG: begin
        next_rdata = slot_cfg_word;
      end
      `BCR_OFF_BRIDGE_STATUS: begin
        next_rdata = status_word;
      end
      default: begin
        next_mapped = 1'b0;
      end
    endcase
  end

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_axi_rvalid <= 1'b0;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Data and response only move on a taken read, so both stand until rready.
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `BCR_RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_mapped ? `BCR_RESP_OKAY : `BCR_RESP_SLVERR;
    end
  end

endmodule

/* bench/bcr_regs_monitor.sv */
// Port checker for the clock-run register bank.
`timescale 1ns/10ps
module bcr_regs_monitor (
  input wire clk_i, resetn_i, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bready,
  input wire s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire l0s_request_i, receiver_elec_idle_i, l0s_enter_o, sec_clock_i,
  input wire sec_clock_stopped_o, slot3_secondary_clock_out_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("Write answer lost.");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("Read answer lost.");
  a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("Read answer late.");
  a_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("Write taken while busy.");
  a_l0s_cause: assert property (l0s_enter_o |-> l0s_request_i)
    else $error("L0s without request.");
  a_l0s_idle: assert property (l0s_request_i && receiver_elec_idle_i |-> l0s_enter_o)
    else $error("L0s refused.");
  a_slot3_src: assert property (slot3_secondary_clock_out_o |-> sec_clock_i)
    else $error("Slot clock invented.");
  a_stop_gate: assert property (sec_clock_stopped_o |-> !slot3_secondary_clock_out_o)
    else $error("Slot clock not gated.");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property ($rose(sec_clock_stopped_o));
  cover property (l0s_enter_o && !receiver_elec_idle_i);
endmodule

/* bench/bcr_host.sv */
// Configuration host model acting as AXI4-Lite master.
`timescale 1ns/10ps
module bcr_host (
  input wire clk_i, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid,
  input wire [1:0] s_axi_bresp, s_axi_rresp,
  input wire [31:0] s_axi_rdata,
  output logic [7:0] s_axi_awaddr, s_axi_araddr,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, hang
);
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, hang} = 6'h0;
  end
  // A stuck slave raises hang rather than blocking the bench forever.
  task automatic go(input w, input [7:0] a, input [31:0] wd, input [3:0] s,
                    output [31:0] d, output [1:0] r);
    int n;
    bit ok;
    n = 0;
    ok = 1'b0;
    @(posedge clk_i);
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} <= {a, a, wd, s};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= {w, w, w, !w, !w};
    while (!ok && n < 40) begin
      @(posedge clk_i);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (w && s_axi_bvalid) {ok, d, r} = {1'b1, 32'h0, s_axi_bresp};
      if (!w && s_axi_rvalid) {ok, d, r} = {1'b1, s_axi_rdata, s_axi_rresp};
    end
    {s_axi_bready, s_axi_rready} <= 2'h0;
    hang <= !ok;
  endtask
endmodule

/* bench/tb.sv */
// Self-checking bench for the clock-run and capability register bank.
`timescale 1ns/10ps
module tb;
  logic clk_i, resetn_i, reverse_bridge_i, d3hot_i, secondary_bus_idle_i, l0s_request_i;
  logic primary_request_pending_i, receiver_elec_idle_i, eeprom_cfg_write_i;
  logic eeprom_slot_id_en_i, sec_clock_i, hang, sec_clock_stopped_o, l0s_enter_o;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic slot0_secondary_clock_out_o, slot3_secondary_clock_out_o;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb, slot_clock_out_o;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  int n_mismatch, n_checks;
  bcr_regs #(.CARD_VENDOR_ID(16'h1234), .CARD_ID(16'h5678)) i_dut (.*);
  bcr_host i_host (.*);
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  always @(posedge clk_i) sec_clock_i <= (sec_clock_i !== 1'b1);
  task chk(input [31:0] got, input [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task rc(input [7:0] a, input [31:0] e, input [1:0] er);
    i_host.go(1'b0, a, 32'h0, 4'h0, d, r);
    chk(d, e);
    chk(r, er);
  endtask
  task wc(input [7:0] a, input [31:0] v, input [3:0] s);
    i_host.go(1'b1, a, v, s, d, r);
    chk(r, 2'h0);
  endtask
  // The raw clock toggles every cycle, so two samples tell a running slot clock.
  task seen(input e);
    logic s3;
    logic s0;
    s3 = 1'b0;
    s0 = 1'b0;
    repeat (2) @(negedge clk_i) begin
      s3 = s3 | slot3_secondary_clock_out_o;
      s0 = s0 | slot0_secondary_clock_out_o;
    end
    chk(s3, e);
    chk(s0, e);
  endtask
  task complete_run;
    $display("Checks %0d, mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    wait (hang === 1'b1);
    n_mismatch++;
    complete_run;
  end
  initial begin
    {resetn_i, reverse_bridge_i, d3hot_i, secondary_bus_idle_i, l0s_request_i} = 5'h0;
    {primary_request_pending_i, receiver_elec_idle_i, eeprom_cfg_write_i} = 3'h0;
    eeprom_slot_id_en_i = 1'b0;
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    rc(8'ha4, 32'h00010000, 2'h0);
    rc(8'ha8, 32'h0000b00d, 2'h0);
    rc(8'hac, 32'h56781234, 2'h0);
    rc(8'hb0, 32'h0071f010, 2'h0);
    rc(8'h10, 32'h0, 2'h2);
    i_host.go(1'b1, 8'h14, 32'hffffffff, 4'hf, d, r);
    chk(r, 2'h2);
    wc(8'ha4, 32'hffffffff, 4'h3);
    rc(8'ha4, 32'h0001c0ff, 2'h0);
    seen(1'b0);
    wc(8'ha4, 32'h0000c080, 4'hf);
    seen(1'b1);
    secondary_bus_idle_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk(sec_clock_stopped_o, 1'b1);
    seen(1'b0);
    rc(8'ha4, 32'h0000e080, 2'h0);
    primary_request_pending_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk(sec_clock_stopped_o, 1'b0);
    wc(8'ha4, 32'h00004000, 4'hf);
    primary_request_pending_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk(sec_clock_stopped_o, 1'b0);
    d3hot_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk(sec_clock_stopped_o, 1'b1);
    {d3hot_i, reverse_bridge_i} <= 2'h1;
    wc(8'ha4, 32'h000000c0, 4'hf);
    seen(1'b1);
    rc(8'hb0, 32'h0181f010, 2'h0);
    {eeprom_slot_id_en_i, eeprom_cfg_write_i} <= 2'h3;
    @(posedge clk_i);
    eeprom_cfg_write_i <= 1'b0;
    wc(8'ha8, 32'hffffffff, 4'hf);
    rc(8'ha8, 32'h0000a00d, 2'h0);
    wc(8'ha4, 32'h0, 4'hf);
    l0s_request_i <= 1'b1;
    @(posedge clk_i);
    chk(l0s_enter_o, 1'b1);
    wc(8'ha4, 32'h00010000, 4'hf);
    chk(l0s_enter_o, 1'b0);
    complete_run;
  end
endmodule
bind bcr_regs bcr_regs_monitor i_mon (.*);
